// ---- rtl/pxe_indicate_encoder.sv ----
// Receive symbol pair to indicate byte encoder with line state, link error and register port
// How it works
// - Each pair becomes one indicate byte
// - Active state repeats data and control symbols
// - Mixed pair: data zeroed, byte marked control
// - Start delimiter JK enters active state
// - Idle state, non idle pair: unknown code
// - Idle state, idle pair: known code
// - Known bit b3, last state b2-0
// - Idle codes are 0011 and 1011
// - Known bit only when symbols match state
// - Other states, matching pair: known code
// - Other states, mismatching pair: unknown code
// - Invalid in halt, quiet, master, noise, unknown-after-active/idle
// - Link error flag clears on listed conditions
// - Filler byte inserted just ahead of JK
`default_nettype none
module pxe_indicate_encoder (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              pairValid,
   input  wire pxe_pkg::pxe_sym_t kindA,
   input  wire logic [3:0]        nibA,
   input  wire pxe_pkg::pxe_sym_t kindB,
   input  wire logic [3:0]        nibB,
   input  wire logic              offAxisJk,
   input  wire logic              linkErrorSet,
   output logic                   pairReady,
   output logic                   indicateValid,
   output logic [7:0]             indicateByte,
   output logic                   indicateCtl,
   output logic                   phy_not_valid,
   output logic                   linkErrorFlag,
   output logic                   irq,
   input  wire logic [3:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic [7:0]             regRdData
);
   logic [7:0]         ctrl;
   logic [pxe_pkg::NUM_EV-1:0] status;
   logic [pxe_pkg::NUM_EV-1:0] mask;
   logic [pxe_pkg::NUM_EV-1:0] events;
   logic               fillValid;
   pxe_pkg::pxe_sym_t  fillKindA;
   pxe_pkg::pxe_sym_t  fillKindB;
   logic [3:0]         fillNibA;
   logic [3:0]         fillNibB;
   logic               fillFiller;
   logic               lastFiller;
   pxe_pkg::pxe_ls_t   lineState;
   pxe_pkg::pxe_ls_t   priorState;
   pxe_pkg::pxe_ls_t   next_lineState;
   logic               ctlA;
   logic               ctlB;
   logic               pairJk;
   logic               pairII;
   logic               pairMatch;
   logic [7:0]         next_indicateByte;
   logic               next_indicateCtl;
   logic               next_invalid;
   logic               lsCode;
   logic               clearLinkError;
   logic               prevInvalid;

   function automatic logic [3:0] ctlNibble(input pxe_pkg::pxe_sym_t k);
      case (k)
         pxe_pkg::SYM_I: ctlNibble = pxe_pkg::CTL_I;
         pxe_pkg::SYM_J: ctlNibble = pxe_pkg::CTL_J;
         pxe_pkg::SYM_K: ctlNibble = pxe_pkg::CTL_K;
         pxe_pkg::SYM_T: ctlNibble = pxe_pkg::CTL_T;
         pxe_pkg::SYM_R: ctlNibble = pxe_pkg::CTL_R;
         pxe_pkg::SYM_S: ctlNibble = pxe_pkg::CTL_S;
         pxe_pkg::SYM_H: ctlNibble = pxe_pkg::CTL_H;
         pxe_pkg::SYM_Q: ctlNibble = pxe_pkg::CTL_Q;
         default:        ctlNibble = pxe_pkg::CTL_V;
      endcase
   endfunction

   pxe_filler_insert u_filler (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .pairValid (pairValid),
      .kindA     (kindA),
      .nibA      (nibA),
      .kindB     (kindB),
      .nibB      (nibB),
      .insertReq (offAxisJk || ctrl[pxe_pkg::CTRL_RECENTER]),
      .pairReady (pairReady),
      .outValid  (fillValid),
      .outKindA  (fillKindA),
      .outNibA   (fillNibA),
      .outKindB  (fillKindB),
      .outNibB   (fillNibB),
      .outFiller (fillFiller)
   );

   pxe_line_state u_state (
      .ref_clk        (ref_clk),
      .reset_n        (reset_n),
      .pairValid      (fillValid),
      .kindA          (fillKindA),
      .kindB          (fillKindB),
      .lineState      (lineState),
      .priorState     (priorState),
      .next_lineState (next_lineState)
   );

   assign ctlA   = (fillKindA != pxe_pkg::SYM_DATA);
   assign ctlB   = (fillKindB != pxe_pkg::SYM_DATA);
   assign pairJk = (fillKindA == pxe_pkg::SYM_J) && (fillKindB == pxe_pkg::SYM_K);
   assign pairII = (fillKindA == pxe_pkg::SYM_I) && (fillKindB == pxe_pkg::SYM_I);

   // Does the pair agree with the state it leaves the line in
   always_comb begin
      case (next_lineState)
         pxe_pkg::LS_IDLE:   pairMatch = pairII;
         pxe_pkg::LS_HALT:   pairMatch = (fillKindA == pxe_pkg::SYM_H) && (fillKindB == pxe_pkg::SYM_H);
         pxe_pkg::LS_QUIET:  pairMatch = (fillKindA == pxe_pkg::SYM_Q) && (fillKindB == pxe_pkg::SYM_Q);
         pxe_pkg::LS_MASTER: pairMatch = (fillKindA == pxe_pkg::SYM_H && fillKindB == pxe_pkg::SYM_Q)
                                      || (fillKindA == pxe_pkg::SYM_Q && fillKindB == pxe_pkg::SYM_H);
         pxe_pkg::LS_NOISE:  pairMatch = (fillKindA == pxe_pkg::SYM_V) || (fillKindB == pxe_pkg::SYM_V);
         default:            pairMatch = 1'b0;
      endcase
   end

   always_comb begin
      next_indicateByte = pxe_pkg::RESET_BYTE;
      next_indicateCtl  = 1'b1;
      lsCode            = 1'b0;
      if (next_lineState == pxe_pkg::LS_ACTIVE) begin
         next_indicateCtl = ctlA || ctlB;
         next_indicateByte[7:4] = ctlA ? ctlNibble(fillKindA)
                                : (ctlB ? pxe_pkg::ZERO_NIBBLE : fillNibA);
         next_indicateByte[3:0] = ctlB ? ctlNibble(fillKindB)
                                : (ctlA ? pxe_pkg::ZERO_NIBBLE : fillNibB);
      end else if (next_lineState == pxe_pkg::LS_IDLE) begin
         lsCode = 1'b1;
         next_indicateByte = {pxe_pkg::LS_MARK,
                              pairII ? pxe_pkg::IDLE_KNOWN_CODE : pxe_pkg::IDLE_UNKNOWN_CODE};
      end else begin
         lsCode = 1'b1;
         next_indicateByte = {pxe_pkg::LS_MARK, pairMatch, next_lineState};
      end
   end

   // Output stage: one byte per taken pair, two cycles after the source handshake
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         indicateValid <= 1'b0;
         indicateByte  <= pxe_pkg::RESET_BYTE;
         indicateCtl   <= 1'b0;
      end else begin
         indicateValid <= fillValid;
         if (fillValid) begin
            indicateByte <= next_indicateByte;
            indicateCtl  <= next_indicateCtl;
         end
      end
   end

   assign next_invalid = (lineState == pxe_pkg::LS_HALT) || (lineState == pxe_pkg::LS_QUIET)
                      || (lineState == pxe_pkg::LS_MASTER) || (lineState == pxe_pkg::LS_NOISE)
                      || ((lineState == pxe_pkg::LS_UNKNOWN)
                          && (priorState == pxe_pkg::LS_ACTIVE || priorState == pxe_pkg::LS_IDLE));
   assign phy_not_valid = next_invalid;

   assign clearLinkError = fillValid && (
         ((lineState == pxe_pkg::LS_ACTIVE || lineState == pxe_pkg::LS_IDLE) && pairJk)
      || ((lineState == pxe_pkg::LS_UNKNOWN) && (priorState == pxe_pkg::LS_ACTIVE) && linkErrorFlag
          && !lastFiller && !pairJk && !pairII
          && !(fillKindA == pxe_pkg::SYM_H && (fillKindB == pxe_pkg::SYM_H || fillKindB == pxe_pkg::SYM_I))));

   // Set wins: an error in the clearing cycle is kept
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         linkErrorFlag <= 1'b0;
      end else if (linkErrorSet) begin
         linkErrorFlag <= 1'b1;
      end else if (clearLinkError) begin
         linkErrorFlag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lastFiller <= 1'b0;
      end else if (fillValid) begin
         lastFiller <= fillFiller;
      end
   end

   assign events[pxe_pkg::EV_ACTIVE]   = fillValid && pairJk && (lineState != pxe_pkg::LS_ACTIVE);
   // Line resets to quiet, already invalid, so no false rise after reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prevInvalid <= 1'b1;
      end else begin
         prevInvalid <= next_invalid;
      end
   end

   assign events[pxe_pkg::EV_INVALID]  = next_invalid && !prevInvalid;
   assign events[pxe_pkg::EV_FILLER]   = fillValid && fillFiller;
   assign events[pxe_pkg::EV_MISMATCH] = fillValid && lsCode && !next_indicateByte[pxe_pkg::KNOWN_BIT];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= '0;
      end else begin
         status <= (status & ~((regWr && regAddr == pxe_pkg::REG_STATUS)
                   ? regWrData[pxe_pkg::NUM_EV-1:0] : '0)) | events;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mask <= '0;
         ctrl <= pxe_pkg::RESET_BYTE;
      end else if (regWr) begin
         if (regAddr == pxe_pkg::REG_MASK) begin
            mask <= regWrData[pxe_pkg::NUM_EV-1:0];
         end
         if (regAddr == pxe_pkg::REG_CTRL) begin
            ctrl <= regWrData;
         end
      end
   end

   assign irq = |(status & mask);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= pxe_pkg::RESET_BYTE;
      end else if (regRd) begin
         case (regAddr)
            pxe_pkg::REG_STATUS: regRdData <= {4'h0, status};
            pxe_pkg::REG_MASK:   regRdData <= {4'h0, mask};
            pxe_pkg::REG_LINE:   regRdData <= {priorState, lineState, next_invalid, linkErrorFlag};
            pxe_pkg::REG_CTRL:   regRdData <= ctrl;
            default:             regRdData <= pxe_pkg::RESET_BYTE;
         endcase
      end else begin
         regRdData <= pxe_pkg::RESET_BYTE;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_jk_enters_active: assert property (fillValid && pairJk |=> lineState == pxe_pkg::LS_ACTIVE)
      else $error("JK pair did not enter active state");
   a_data_repeat: assert property (fillValid && next_lineState == pxe_pkg::LS_ACTIVE && !ctlA && !ctlB
      |=> indicateValid && !indicateCtl && indicateByte == {$past(fillNibA), $past(fillNibB)})
      else $error("Data pair not repeated");
   a_mixed_zero: assert property (fillValid && next_lineState == pxe_pkg::LS_ACTIVE && ctlA && !ctlB
      |=> indicateCtl && indicateByte[3:0] == pxe_pkg::ZERO_NIBBLE)
      else $error("Mixed pair data not zeroed");
   a_idle_known: assert property (fillValid && pairII |=> indicateByte == {pxe_pkg::LS_MARK, pxe_pkg::IDLE_KNOWN_CODE})
      else $error("Idle pair not known idle code");
   a_idle_unknown: assert property (fillValid && !pairII && next_lineState == pxe_pkg::LS_IDLE
      |=> indicateByte == {pxe_pkg::LS_MARK, pxe_pkg::IDLE_UNKNOWN_CODE})
      else $error("Non idle pair in idle not unknown code");
   a_state_field: assert property (indicateValid && indicateCtl && indicateByte[7:4] == pxe_pkg::LS_MARK
      |-> indicateByte[2:0] == lineState)
      else $error("State field differs from line state");
   a_halt_invalid: assert property (fillValid && fillKindA == pxe_pkg::SYM_H && fillKindB == pxe_pkg::SYM_H
      |=> phy_not_valid)
      else $error("Halt not flagged invalid");
   a_link_clear: assert property (fillValid && pairJk && lineState == pxe_pkg::LS_IDLE && !linkErrorSet
      |=> !linkErrorFlag)
      else $error("Link error flag not cleared on JK");
   a_filler_then_jk: assert property (fillValid && fillFiller |=> fillValid && pairJk ##1 !fillFiller)
      else $error("Filler byte not followed by JK");
   a_one_byte: assert property (fillValid |=> indicateValid)
      else $error("Pair produced no byte");

   c_frame_start: cover property (fillValid && fillFiller ##1 pairJk ##1 indicateCtl);
   c_idle_to_active: cover property (lineState == pxe_pkg::LS_IDLE ##1 lineState == pxe_pkg::LS_ACTIVE);
   c_link_clear: cover property (linkErrorFlag ##1 !linkErrorFlag);
   c_irq: cover property (irq);
endmodule
`default_nettype wire

// ---- shared/pxe_pkg.sv ----
// Shared constants and types for the indicate byte encoder
`default_nettype none
package pxe_pkg;
   typedef enum logic [3:0] {
      SYM_DATA = 4'h0,
      SYM_I    = 4'h1,
      SYM_J    = 4'h2,
      SYM_K    = 4'h3,
      SYM_T    = 4'h4,
      SYM_R    = 4'h5,
      SYM_S    = 4'h6,
      SYM_H    = 4'h7,
      SYM_Q    = 4'h8,
      SYM_V    = 4'h9
   } pxe_sym_t;

   typedef enum logic [2:0] {
      LS_QUIET   = 3'h0,
      LS_HALT    = 3'h1,
      LS_MASTER  = 3'h2,
      LS_IDLE    = 3'h3,
      LS_NOISE   = 3'h4,
      LS_ACTIVE  = 3'h5,
      LS_UNKNOWN = 3'h6
   } pxe_ls_t;

   // Indicate byte layout
   localparam logic [3:0] LS_MARK          = 4'h1;
   localparam int         KNOWN_BIT        = 3;
   localparam logic [3:0] ZERO_NIBBLE      = 4'h0;
   localparam logic [3:0] IDLE_UNKNOWN_CODE = 4'h3;
   localparam logic [3:0] IDLE_KNOWN_CODE   = 4'hB;
   // Control symbol nibbles sit above 4'h7 so they never alias the line-state marker
   localparam logic [3:0] CTL_I = 4'h8;
   localparam logic [3:0] CTL_J = 4'h9;
   localparam logic [3:0] CTL_K = 4'hA;
   localparam logic [3:0] CTL_T = 4'hB;
   localparam logic [3:0] CTL_R = 4'hC;
   localparam logic [3:0] CTL_S = 4'hD;
   localparam logic [3:0] CTL_H = 4'hE;
   localparam logic [3:0] CTL_Q = 4'hF;
   localparam logic [3:0] CTL_V = 4'h8;

   // Register map
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK   = 4'h4;
   localparam logic [3:0] REG_LINE   = 4'h8;
   localparam logic [3:0] REG_CTRL   = 4'hC;
   localparam int         EV_ACTIVE  = 0;
   localparam int         EV_INVALID = 1;
   localparam int         EV_FILLER  = 2;
   localparam int         EV_MISMATCH = 3;
   localparam int         NUM_EV     = 4;
   localparam int         CTRL_RECENTER = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage
`default_nettype wire

// ---- rtl/pxe_filler_insert.sv ----
// Filler byte insertion ahead of a start delimiter pair
`default_nettype none
module pxe_filler_insert (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              pairValid,
   input  wire pxe_pkg::pxe_sym_t kindA,
   input  wire logic [3:0]        nibA,
   input  wire pxe_pkg::pxe_sym_t kindB,
   input  wire logic [3:0]        nibB,
   input  wire logic              insertReq,
   output logic                   pairReady,
   output logic                   outValid,
   output pxe_pkg::pxe_sym_t      outKindA,
   output logic [3:0]             outNibA,
   output pxe_pkg::pxe_sym_t      outKindB,
   output logic [3:0]             outNibB,
   output logic                   outFiller
);
   logic holdJk;
   logic isJk;

   assign isJk = (kindA == pxe_pkg::SYM_J) && (kindB == pxe_pkg::SYM_K);
   // Source stalls for the one slot the filler steals
   assign pairReady = !holdJk;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         holdJk    <= 1'b0;
         outValid  <= 1'b0;
         outFiller <= 1'b0;
         outKindA  <= pxe_pkg::SYM_I;
         outKindB  <= pxe_pkg::SYM_I;
         outNibA   <= pxe_pkg::ZERO_NIBBLE;
         outNibB   <= pxe_pkg::ZERO_NIBBLE;
      end else if (holdJk) begin
         holdJk    <= 1'b0;
         outValid  <= 1'b1;
         outFiller <= 1'b0;
         outKindA  <= pxe_pkg::SYM_J;
         outKindB  <= pxe_pkg::SYM_K;
         outNibA   <= pxe_pkg::ZERO_NIBBLE;
         outNibB   <= pxe_pkg::ZERO_NIBBLE;
      end else if (pairValid && isJk && insertReq) begin
         holdJk    <= 1'b1;
         outValid  <= 1'b1;
         outFiller <= 1'b1;
         outKindA  <= pxe_pkg::SYM_I;
         outKindB  <= pxe_pkg::SYM_I;
         outNibA   <= pxe_pkg::ZERO_NIBBLE;
         outNibB   <= pxe_pkg::ZERO_NIBBLE;
      end else begin
         outValid  <= pairValid;
         outFiller <= 1'b0;
         if (pairValid) begin
            outKindA <= kindA;
            outKindB <= kindB;
            outNibA  <= nibA;
            outNibB  <= nibB;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/pxe_line_state.sv ----
// Line state detector with prior line state tracking
`default_nettype none
module pxe_line_state (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              pairValid,
   input  wire pxe_pkg::pxe_sym_t kindA,
   input  wire pxe_pkg::pxe_sym_t kindB,
   output pxe_pkg::pxe_ls_t       lineState,
   output pxe_pkg::pxe_ls_t       priorState,
   output pxe_pkg::pxe_ls_t       next_lineState
);
   logic isCtlH;
   logic isCtlQ;
   logic anyV;

   assign isCtlH = (kindA == pxe_pkg::SYM_H) || (kindB == pxe_pkg::SYM_H);
   assign isCtlQ = (kindA == pxe_pkg::SYM_Q) || (kindB == pxe_pkg::SYM_Q);
   assign anyV   = (kindA == pxe_pkg::SYM_V) || (kindB == pxe_pkg::SYM_V);

   always_comb begin
      next_lineState = lineState;
      if (pairValid) begin
         if (kindA == pxe_pkg::SYM_J && kindB == pxe_pkg::SYM_K) begin
            next_lineState = pxe_pkg::LS_ACTIVE;
         end else if (anyV) begin
            next_lineState = pxe_pkg::LS_NOISE;
         end else if (kindA == pxe_pkg::SYM_I && kindB == pxe_pkg::SYM_I) begin
            next_lineState = pxe_pkg::LS_IDLE;
         end else if (kindA == pxe_pkg::SYM_H && kindB == pxe_pkg::SYM_H) begin
            next_lineState = pxe_pkg::LS_HALT;
         end else if (kindA == pxe_pkg::SYM_Q && kindB == pxe_pkg::SYM_Q) begin
            next_lineState = pxe_pkg::LS_QUIET;
         end else if (isCtlH && isCtlQ) begin
            next_lineState = pxe_pkg::LS_MASTER;
         end else if (lineState == pxe_pkg::LS_ACTIVE && (isCtlH || isCtlQ)) begin
            // Frame broken by line-state symbols
            next_lineState = pxe_pkg::LS_UNKNOWN;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lineState  <= pxe_pkg::LS_QUIET;
         priorState <= pxe_pkg::LS_QUIET;
      end else if (next_lineState != lineState) begin
         lineState  <= next_lineState;
         priorState <= lineState;
      end
   end
endmodule
`default_nettype wire

// ---- dv/pxe_mac_model.sv ----
// Indicate port sink standing in for the media access controller
`default_nettype none
module pxe_mac_model (
   input wire logic       ref_clk,
   input wire logic       reset_n,
   input wire logic       indicateValid,
   input wire logic [7:0] indicateByte,
   input wire logic       indicateCtl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] got[$];
   // Looks every clock; a held byte is not a new one, so only valid pulses count
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         got.delete();
      end else if (indicateValid === 1'b1) begin
         got.push_back({indicateCtl, indicateByte});
      end
   end
endmodule
`default_nettype wire

// ---- dv/pxe_indicate_encoder_bench.sv ----
// Self-checking bench for the indicate byte encoder
`default_nettype none
module pxe_indicate_encoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              pairValid = 1'b0;
   pxe_pkg::pxe_sym_t kindA = pxe_pkg::SYM_DATA;
   pxe_pkg::pxe_sym_t kindB = pxe_pkg::SYM_DATA;
   logic [3:0]        nibA = 4'h0;
   logic [3:0]        nibB = 4'h0;
   logic              offAxisJk = 1'b0;
   logic              linkErrorSet = 1'b0;
   logic [3:0]        regAddr = 4'h0;
   logic [7:0]        regWrData = 8'h00;
   logic              regWr = 1'b0;
   logic              regRd = 1'b0;
   logic              pairReady;
   logic              indicateValid;
   logic [7:0]        indicateByte;
   logic              indicateCtl;
   logic              phy_not_valid;
   logic              linkErrorFlag;
   logic              irq;
   logic [7:0]        regRdData;
   int                errors = 0;
   int                checkCount = 0;

   always #5 ref_clk = ~ref_clk;

   pxe_indicate_encoder dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .pairValid(pairValid), .kindA(kindA),
      .nibA(nibA), .kindB(kindB), .nibB(nibB), .offAxisJk(offAxisJk), .linkErrorSet(linkErrorSet),
      .pairReady(pairReady), .indicateValid(indicateValid), .indicateByte(indicateByte),
      .indicateCtl(indicateCtl), .phy_not_valid(phy_not_valid), .linkErrorFlag(linkErrorFlag), .irq(irq),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

   pxe_mac_model mac_u (.ref_clk(ref_clk), .reset_n(reset_n), .indicateValid(indicateValid),
      .indicateByte(indicateByte), .indicateCtl(indicateCtl));

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] lsCode(input logic known, input pxe_pkg::pxe_ls_t st);
      return {pxe_pkg::LS_MARK, known, st};
   endfunction

   // Holds the pair until an edge sees it accepted
   task automatic sendPair(input pxe_pkg::pxe_sym_t ka, input logic [3:0] na, input pxe_pkg::pxe_sym_t kb,
                           input logic [3:0] nb, input logic off);
      logic rdy;
      @(posedge ref_clk);
      pairValid <= 1'b1;
      kindA <= ka;
      nibA <= na;
      kindB <= kb;
      nibB <= nb;
      offAxisJk <= off;
      for (int i = 0; i < 20; i++) begin
         @(negedge ref_clk);
         rdy = pairReady;
         @(posedge ref_clk);
         if (rdy === 1'b1) begin
            break;
         end
      end
      pairValid <= 1'b0;
      offAxisJk <= 1'b0;
   endtask

   task automatic expectByte(input logic [7:0] exp, input logic ctl);
      logic [8:0] got;
      for (int n = 0; n < 20 && mac_u.got.size() == 0; n++) begin
         @(negedge ref_clk);
      end
      got = (mac_u.got.size() != 0) ? mac_u.got.pop_front() : 9'h1FF;
      cmp8(got[7:0], exp);
      cmp1(got[8], ctl);
   endtask

   task automatic regWrite(input logic [3:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= addr;
      regWrData <= data;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask

   task automatic regRead(input logic [3:0] addr, input logic [7:0] exp, input logic [7:0] care);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= addr;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      cmp8(regRdData & care, exp);
   endtask

   task automatic pulseLinkErr();
      @(posedge ref_clk);
      linkErrorSet <= 1'b1;
      @(posedge ref_clk);
      linkErrorSet <= 1'b0;
      @(negedge ref_clk);
      cmp1(linkErrorFlag, 1'b1);
   endtask

   task automatic checkReset();
      @(negedge ref_clk);
      cmp1(phy_not_valid, 1'b1);
      regRead(pxe_pkg::REG_LINE, {pxe_pkg::LS_QUIET, pxe_pkg::LS_QUIET, 2'b10}, 8'hFF);
      regRead(pxe_pkg::REG_MASK, 8'h00, 8'hFF);
      regRead(4'h2, 8'h00, 8'hFF);
   endtask

   task automatic checkIdle();
      sendPair(pxe_pkg::SYM_I, 4'h0, pxe_pkg::SYM_I, 4'h0, 1'b0);
      @(negedge ref_clk);
      cmp1(indicateValid, 1'b0);
      @(negedge ref_clk);
      cmp1(indicateValid, 1'b1);
      @(negedge ref_clk);
      cmp1(indicateValid, 1'b0);
      expectByte(lsCode(1'b1, pxe_pkg::LS_IDLE), 1'b1);
      cmp1(phy_not_valid, 1'b0);
      sendPair(pxe_pkg::SYM_I, 4'h0, pxe_pkg::SYM_DATA, 4'h5, 1'b0);
      expectByte(lsCode(1'b0, pxe_pkg::LS_IDLE), 1'b1);
   endtask

   task automatic checkFiller();
      regWrite(pxe_pkg::REG_STATUS, 8'hFF);
      regWrite(pxe_pkg::REG_MASK, 8'h04);
      sendPair(pxe_pkg::SYM_J, 4'h0, pxe_pkg::SYM_K, 4'h0, 1'b1);
      @(negedge ref_clk);
      cmp1(pairReady, 1'b0);
      sendPair(pxe_pkg::SYM_DATA, 4'h3, pxe_pkg::SYM_DATA, 4'hC, 1'b0);
      expectByte(lsCode(1'b1, pxe_pkg::LS_IDLE), 1'b1);
      expectByte({pxe_pkg::CTL_J, pxe_pkg::CTL_K}, 1'b1);
      expectByte(8'h3C, 1'b0);
      regRead(pxe_pkg::REG_STATUS, 8'h05, 8'h05);
      cmp1(irq, 1'b1);
      regWrite(pxe_pkg::REG_STATUS, 8'h04);
      @(negedge ref_clk);
      cmp1(irq, 1'b0);
      regRead(pxe_pkg::REG_STATUS, 8'h00, 8'h04);
      regWrite(pxe_pkg::REG_MASK, 8'h00);
   endtask

   task automatic checkActive();
      sendPair(pxe_pkg::SYM_DATA, 4'h7, pxe_pkg::SYM_T, 4'h0, 1'b0);
      expectByte({pxe_pkg::ZERO_NIBBLE, pxe_pkg::CTL_T}, 1'b1);
      sendPair(pxe_pkg::SYM_S, 4'h0, pxe_pkg::SYM_DATA, 4'h9, 1'b0);
      expectByte({pxe_pkg::CTL_S, pxe_pkg::ZERO_NIBBLE}, 1'b1);
      sendPair(pxe_pkg::SYM_R, 4'h0, pxe_pkg::SYM_T, 4'h0, 1'b0);
      expectByte({pxe_pkg::CTL_R, pxe_pkg::CTL_T}, 1'b1);
   endtask

   task automatic checkUnknown();
      sendPair(pxe_pkg::SYM_H, 4'h0, pxe_pkg::SYM_DATA, 4'h1, 1'b0);
      expectByte(lsCode(1'b0, pxe_pkg::LS_UNKNOWN), 1'b1);
      cmp1(phy_not_valid, 1'b1);
      regRead(pxe_pkg::REG_LINE, {pxe_pkg::LS_ACTIVE, pxe_pkg::LS_UNKNOWN, 2'b10}, 8'hFF);
      regRead(pxe_pkg::REG_STATUS, 8'h0A, 8'h0A);
      pulseLinkErr();
      sendPair(pxe_pkg::SYM_DATA, 4'h1, pxe_pkg::SYM_DATA, 4'h2, 1'b0);
      expectByte(lsCode(1'b0, pxe_pkg::LS_UNKNOWN), 1'b1);
      cmp1(linkErrorFlag, 1'b0);
   endtask

   task automatic checkOther();
      pxe_pkg::pxe_sym_t ka[5] = '{pxe_pkg::SYM_H, pxe_pkg::SYM_H, pxe_pkg::SYM_H, pxe_pkg::SYM_Q, pxe_pkg::SYM_V};
      pxe_pkg::pxe_sym_t kb[5] = '{pxe_pkg::SYM_H, pxe_pkg::SYM_I, pxe_pkg::SYM_Q, pxe_pkg::SYM_Q, pxe_pkg::SYM_V};
      pxe_pkg::pxe_ls_t  st[5] = '{pxe_pkg::LS_HALT, pxe_pkg::LS_HALT, pxe_pkg::LS_MASTER, pxe_pkg::LS_QUIET,
                                   pxe_pkg::LS_NOISE};
      logic              kn[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      for (int i = 0; i < 5; i++) begin
         sendPair(ka[i], 4'h0, kb[i], 4'h0, 1'b0);
         expectByte(lsCode(kn[i], st[i]), 1'b1);
         cmp1(phy_not_valid, 1'b1);
      end
   endtask

   task automatic checkClear();
      sendPair(pxe_pkg::SYM_I, 4'h0, pxe_pkg::SYM_I, 4'h0, 1'b0);
      expectByte(lsCode(1'b1, pxe_pkg::LS_IDLE), 1'b1);
      pulseLinkErr();
      sendPair(pxe_pkg::SYM_J, 4'h0, pxe_pkg::SYM_K, 4'h0, 1'b0);
      expectByte({pxe_pkg::CTL_J, pxe_pkg::CTL_K}, 1'b1);
      cmp1(linkErrorFlag, 1'b0);
      // Recenter request alone must still place a filler ahead of the delimiter
      regWrite(pxe_pkg::REG_CTRL, 8'h01);
      sendPair(pxe_pkg::SYM_J, 4'h0, pxe_pkg::SYM_K, 4'h0, 1'b0);
      expectByte(lsCode(1'b1, pxe_pkg::LS_IDLE), 1'b1);
      expectByte({pxe_pkg::CTL_J, pxe_pkg::CTL_K}, 1'b1);
      regWrite(pxe_pkg::REG_CTRL, 8'h00);
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      checkReset();
      checkIdle();
      checkFiller();
      checkActive();
      checkUnknown();
      checkOther();
      checkClear();
      summarize();
   end

   // Whole run is well under a thousand cycles
   initial begin
      #100us;
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
